// ===== bench/vph_bus_model.sv
// Bus transceiver and second node on the far side of the handler
// Assumes high means active on both pins; passive bus is pulled low
`timescale 1ns/1ps
module vph_bus_model (
  // Device side
  input wire logic tx_in,
  // Other node and fault injection: 1 stuck active, 2 stuck passive
  input wire logic node_act_in,
  input wire logic [1:0] fault_in,
  // Line seen by the device
  output logic line_out
);
  // Wired OR: any active driver dominates, faults override all
  assign line_out = (fault_in == 2'h1) ? 1'b1 :
                    (fault_in == 2'h2) ? 1'b0 :
                    (tx_in | node_act_in);
endmodule

// ===== bench/vph_handler_monitor.sv
// Concurrent checks on the handler ports
// Assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module vph_handler_monitor
  import vph_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Pins
  input wire logic rx_input_pin_in,
  input wire logic tx_output_pin_out,
  input wire logic irq_out
);
  // Margin covers the input synchroniser
  localparam int MIS_MAX = 520;
  localparam int SOF_MAX = 4020;
  localparam int IDLE_MIN = 5000;
  logic ie_q;
  logic armed_q;
  logic [11:0] mis_q;
  logic [11:0] act_q;
  logic [12:0] low_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ie_q <= 1'b0;
      armed_q <= 1'b0;
      mis_q <= 12'h000;
      act_q <= 12'h000;
      low_q <= 13'h0000;
    end else begin
      if (reg_wr_in && reg_addr_in == 2'h0) begin
        ie_q <= reg_wdata_in[0];
      end
      if (reg_wr_in && reg_addr_in == 2'h3) begin
        armed_q <= 1'b1;
      end else if (tx_output_pin_out && low_q >= IDLE_MIN) begin
        armed_q <= 1'b0;
      end
      mis_q <= (tx_output_pin_out && !rx_input_pin_in) ?
               mis_q + 12'h001 : 12'h000;
      act_q <= tx_output_pin_out ? act_q + 12'h001 : 12'h000;
      low_q <= tx_output_pin_out ? 13'h0000 :
               (low_q == 13'h1FFF) ? low_q : low_q + 13'h0001;
    end
  end
  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  rdata_quiet_a: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 8'h00) else $error("read data not quiet");
  sv_code_a: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == 2'h2 |->
    reg_rdata_out[1:0] == 2'b00 && reg_rdata_out <= 8'h1C)
    else $error("bad state code");
  irq_gate_a: assert property (irq_out |-> $past(ie_q))
    else $error("irq without enable");
  irq_hold_a: assert property ($fell(irq_out) |->
    $past(reg_rd_in) || $past(reg_wr_in) ||
    $past(reg_rd_in, 2) || $past(reg_wr_in, 2))
    else $error("irq dropped without access");
  tx_start_a: assert property ($rose(tx_output_pin_out) |->
    !$past(rx_input_pin_in)) else $error("tx on active bus");
  tx_fault_a: assert property (mis_q <= MIS_MAX)
    else $error("undriven bus not aborted");
  sof_max_a: assert property (act_q <= SOF_MAX)
    else $error("active pulse too long");
  no_retry_a: assert property (
    $rose(tx_output_pin_out) && low_q >= IDLE_MIN |-> armed_q)
    else $error("frame without host write");
  cover property ($rose(tx_output_pin_out));
  cover property ($rose(irq_out));
  cover property ($past(reg_rd_in) && reg_rdata_out == 8'h18);
endmodule
bind vph_handler vph_handler_monitor i_mon (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .rx_input_pin_in(rx_input_pin_in),
  .tx_output_pin_out(tx_output_pin_out),
  .irq_out(irq_out)
);

// ===== bench/vph_handler_test.sv
// Self-checking bench for the handler: frames in, frame out, faults
// Assumes the bus model on the pins and a 20 MHz clock
`timescale 1ns/1ps
`include "vph_defs.svh"
module vph_handler_test;
  import vph_pkg::*;
  logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, node_act, tx, irq, pin;
  logic [1:0] reg_addr_in, fault;
  logic [7:0] reg_wdata_in, rdata;
  int num_errors, n_tests, cyc, n;
  vph_handler i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
    .rx_input_pin_in(pin), .tx_output_pin_out(tx), .irq_out(irq));
  vph_bus_model i_bus (.tx_in(tx), .node_act_in(node_act),
    .fault_in(fault), .line_out(pin));
  task automatic close_out;
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    check(rdata, exp);
  endtask
  task automatic hold(input int cycles, input logic lvl);
    @(posedge sys_clk_in);
    node_act <= lvl;
    repeat (cycles - 1) @(posedge sys_clk_in);
  endtask
  // One-byte frame from the other node; sc 4 gives fast rate
  task automatic frame(input logic [7:0] b, input int sc);
    hold(4000 / sc, 1'b1);
    for (int i = 7; i >= 0; i--)
      hold(((b[i] == i[0]) ? 2560 : 1280) / sc, !i[0]);
    hold(5000, 1'b0);
  endtask
  // Cycles until tx changes level, capped at 310 us
  task automatic meas(output int c);
    logic lvl;
    lvl = tx;
    c = 0;
    while (tx === lvl && c < 6200) begin
      @(negedge sys_clk_in);
      c++;
    end
  endtask
  function automatic logic [7:0] crc1(input logic [7:0] b);
    logic [7:0] c;
    c = `VPH_CRC_INIT ^ b;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ `VPH_CRC_POLY) : (c << 1);
    return ~c;
  endfunction
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    logic [15:0] got;
    logic lvl;
    {reg_wr_in, reg_rd_in, node_act, reg_addr_in, fault} = '0;
    reg_wdata_in = 8'h00;
    {num_errors, n_tests, cyc} = '0;
    rst_in = 1'b1;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(2'h2, `VPH_SV_NONE);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'h01);
    rd(2'h0, 8'h01);
    // Normal-rate frame carrying only its correct check byte
    frame(8'h00, 1);
    check({7'h00, irq}, 8'h01);
    rd(2'h2, `VPH_SV_RX_DATA_FULL_FLAG);
    rd(2'h3, 8'h00);
    rd(2'h2, `VPH_SV_EOF);
    rd(2'h2, `VPH_SV_NONE);
    check({7'h00, irq}, 8'h00);
    // Fast frame with a wrong check byte, fast receive enabled
    wr(2'h1, 8'h02);
    rd(2'h1, 8'h02);
    frame(8'h55, 4);
    rd(2'h2, `VPH_SV_CRC);
    rd(2'h2, `VPH_SV_RX_DATA_FULL_FLAG);
    // Loopback hides the pin, so the shadow keeps the old byte
    wr(2'h1, 8'h03);
    frame(8'hA5, 4);
    rd(2'h3, 8'h55);
    wr(2'h1, 8'h00);
    // Own frame: start of frame, byte, check byte, end of data
    wr(2'h3, 8'h55);
    meas(n);
    check({7'h00, tx}, 8'h01);
    meas(n);
    check({7'h00, n > 3980 && n < 4020}, 8'h01);
    for (int i = 15; i >= 0; i--) begin
      lvl = tx;
      meas(n);
      got[i] = (n > 1920) ^ lvl;
    end
    check(got[15:8], 8'h55);
    check(got[7:0], crc1(8'h55));
    meas(n);
    check({7'h00, n == 6200}, 8'h01);
    rd(2'h2, `VPH_SV_TX_DATA_EMPTY_FLAG);
    check({7'h00, irq}, 8'h01);
    // Bus held active: no start; shorted passive: start, then abort
    @(posedge sys_clk_in) fault <= 2'h1;
    // Let the stuck level pass the synchroniser before queueing
    repeat (10) @(posedge sys_clk_in);
    wr(2'h3, 8'hAA);
    meas(n);
    check({7'h00, n == 6200 && tx === 1'b0}, 8'h01);
    @(posedge sys_clk_in) fault <= 2'h2;
    meas(n);
    check({7'h00, tx}, 8'h01);
    meas(n);
    check({7'h00, n < 600}, 8'h01);
    rd(2'h2, `VPH_SV_SYM);
    meas(n);
    check({7'h00, n == 6200}, 8'h01);
    @(posedge sys_clk_in) fault <= 2'h0;
    close_out;
  end
endmodule

// ===== logic/vph_defs.svh
// Constants for the VPW link protocol handler
// Assumes a 20 MHz system clock and a 1 us symbol time base
`ifndef VPH_DEFS_SVH
`define VPH_DEFS_SVH
`define VPH_CLK_HZ 20000000
`define VPH_US_CYC (`VPH_CLK_HZ / 1000000)
`define VPH_DIV_LAST 5'((`VPH_US_CYC) - 1)
// Transmit symbol lengths, microseconds
`define VPH_T_SHORT 10'h040
`define VPH_T_LONG 10'h080
`define VPH_T_SOF 10'h0C8
`define VPH_T_EOD 10'h0C8
// Receive window edges, microseconds
`define VPH_W_MIN 10'h022
`define VPH_W_SL 10'h060
`define VPH_W_LS 10'h0A3
`define VPH_W_EOF 10'h0EF
`define VPH_W_BRK 10'h0EF
`define VPH_W_IDLE 10'h12C
`define VPH_W4_LO 10'h029
`define VPH_W4_HI 10'h03B
`define VPH_CNT_MAX 10'h3FF
`define VPH_LOOP_US 10'h018
// Check byte
`define VPH_CRC_POLY 8'h1D
`define VPH_CRC_INIT 8'hFF
`define VPH_CRC_RES 8'hC4
// State vector codes
`define VPH_SV_NONE 8'h00
`define VPH_SV_EOF 8'h04
`define VPH_SV_IFR 8'h08
`define VPH_SV_RX_DATA_FULL_FLAG 8'h0C
`define VPH_SV_TX_DATA_EMPTY_FLAG 8'h10
`define VPH_SV_LOA 8'h14
`define VPH_SV_CRC 8'h18
`define VPH_SV_SYM 8'h1C
// Register addresses and bits
`define VPH_A_CTL1 2'h0
`define VPH_A_CTL2 2'h1
`define VPH_A_SV 2'h2
`define VPH_A_DATA 2'h3
`define VPH_B_IE 0
`define VPH_B_LOOP 0
`define VPH_B_FAST 1
`define VPH_BIT_LAST 3'h7
`define VPH_APP_N 2'h2
`endif

// ===== logic/vph_handler.sv
// VPW single-wire link protocol handler, device side
// Assumes an external transceiver on the pins, high meaning active,
// and a host on a plain strobe register port
// Operation
// - Completed rx byte to shadow, flag, interrupt
// - Finished tx byte reloads from shadow
// - Loopback bit selects receive source
// - Fast frames received only when enabled
// - Frames of any length accepted
// - Transmit error stops sending, code 1C
// - Bad check residue gives code 18
// - Invalid symbol while sending reports 14 first
// - Abnormal symbol gives 1C, aborts sending
// - Misplaced end symbols give code 1C
// - No transmit start while bus active
// - Undrivable start of frame aborts, code 1C
// - Recovery after fault needs no host
// - Break gives 1C, then wait for start
// - Break recognised only, never sent
// - Framing, arbitration, check byte, errors per frame
// - Recessive sent, dominant read: stop after 24 us of mismatch
// - Loss on first bit after a full byte appends two ones
// - Interrupt held while any source pending
`timescale 1ns/1ps
`include "vph_defs.svh"
module vph_handler
  import vph_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Bus transceiver
  input wire logic rx_input_pin_in,
  output logic tx_output_pin_out,
  // Interrupt request
  output logic irq_out
);
  vph_top_t q, d;
  logic dec_v;
  vph_sym_t dec_sym;
  logic dec_idle;
  logic line;
  logic tx_on;
  logic tx_kill;
  logic load;
  logic nlvl;
  logic nbit;
  logic [7:0] rx_byte;
  logic [7:0] sv;

  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      if (r[7]) r = {r[6:0], 1'b0} ^ `VPH_CRC_POLY;
      else r = {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // Dominant zero: long when active, short when passive
  function automatic logic [9:0] tlen(input logic act,
                                      input logic b);
    return (act ^ b) ? `VPH_T_LONG : `VPH_T_SHORT;
  endfunction

  function automatic logic [7:0] sv_code(input vph_top_t s);
    logic [7:0] c;
    c = `VPH_SV_NONE;
    if (s.f_loa) c = `VPH_SV_LOA;
    else if (s.f_sym) c = `VPH_SV_SYM;
    else if (s.f_crc) c = `VPH_SV_CRC;
    else if (s.f_tx_data_empty_flag) c = `VPH_SV_TX_DATA_EMPTY_FLAG;
    else if (s.f_rx_data_full_flag) c = `VPH_SV_RX_DATA_FULL_FLAG;
    else if (s.f_ifr) c = `VPH_SV_IFR;
    else if (s.f_eof) c = `VPH_SV_EOF;
    return c;
  endfunction

  // Loss of arbitration outranks the error it stacks above
  assign sv = sv_code(q);
  assign line = q.loop ? q.tx_lvl : q.rxl;
  assign tx_on = q.tx_st inside {TX_SOF, TX_BITS, TX_EOD};

  vph_sym_dec u_dec (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .us_tick_in(q.tick),
    .line_in(line),
    .fast_en_in(q.fast_en),
    .sym_valid_out(dec_v),
    .sym_out(dec_sym),
    .idle_out(dec_idle)
  );

  always_comb begin
    d = q;
    tx_kill = 1'b0;
    load = 1'b0;
    nlvl = ~q.tx_lvl;
    nbit = q.tx_sh[6];
    // Pin passes three stages; change taken when last two agree
    d.s1 = rx_input_pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) d.rxl = q.s3;
    // Microsecond time base
    // Free running, so a queued start may wait up to one tick
    d.tick = 1'b0;
    if (q.div == `VPH_DIV_LAST) begin
      d.div = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 5'h01;
    end

    // Register reads; clears come before hardware sets
    d.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `VPH_A_CTL1: d.rdata[`VPH_B_IE] = q.ie;
        `VPH_A_CTL2: begin
          d.rdata[`VPH_B_LOOP] = q.loop;
          d.rdata[`VPH_B_FAST] = q.fast_en;
        end
        `VPH_A_SV: begin
          d.rdata = sv;
          case (sv)
            `VPH_SV_LOA: d.f_loa = 1'b0;
            `VPH_SV_SYM: d.f_sym = 1'b0;
            `VPH_SV_CRC: d.f_crc = 1'b0;
            `VPH_SV_EOF: d.f_eof = 1'b0;
            default: d.f_eof = q.f_eof;
          endcase
        end
        default: begin
          d.rdata = q.rx_buf;
          d.f_rx_data_full_flag = 1'b0;
          d.f_ifr = 1'b0;
        end
      endcase
    end
    if (reg_wr_in && reg_addr_in == `VPH_A_CTL1) begin
      d.ie = reg_wdata_in[`VPH_B_IE];
    end
    if (reg_wr_in && reg_addr_in == `VPH_A_CTL2) begin
      d.loop = reg_wdata_in[`VPH_B_LOOP];
      d.fast_en = reg_wdata_in[`VPH_B_FAST];
    end

    // Receive framing
    // Own frames are received too, so the host sees its echo
    // Shadow is overwritten without hold-off; host must keep up
    rx_byte = {q.rx_sh[6:0], dec_sym == SYM_B1};
    if (dec_v) begin
      case (dec_sym)
        SYM_SOF: begin
          d.rx_st = RX_DATA;
          d.rx_bits = 3'h0;
          d.rx_crc = `VPH_CRC_INIT;
        end
        SYM_B0, SYM_B1: begin
          if (q.rx_st != RX_HUNT) begin
            d.rx_sh = rx_byte;
            d.rx_bits = q.rx_bits + 3'h1;
            // No byte count limit anywhere in a frame
            if (q.rx_bits == `VPH_BIT_LAST) begin
              d.rx_buf = rx_byte;
              d.rx_crc = crc_byte(q.rx_crc, rx_byte);
              if (q.rx_st == RX_DATA) d.f_rx_data_full_flag = 1'b1;
              else d.f_ifr = 1'b1;
            end
          end
        end
        SYM_EOD, SYM_EOF: begin
          if (q.rx_st != RX_HUNT) begin
            d.rx_st = RX_HUNT;
            d.rx_bits = 3'h0;
            if (q.rx_bits != 3'h0) begin
              d.f_sym = 1'b1;
            end else if (q.rx_st == RX_DATA &&
                         q.rx_crc != `VPH_CRC_RES) begin
              d.f_crc = 1'b1;
            end else if (dec_sym == SYM_EOF) begin
              d.f_eof = 1'b1;
            end else begin
              d.rx_st = RX_RESP;
            end
          end
        end
        SYM_BRK: begin
          if (q.rx_st != RX_HUNT || tx_on) begin
            d.f_sym = 1'b1;
            d.rx_st = RX_HUNT;
            tx_kill = tx_on;
          end
        end
        default: begin
          if (q.rx_st != RX_HUNT || tx_on) begin
            d.f_sym = 1'b1;
            if (tx_on) d.f_loa = 1'b1;
            tx_kill = tx_on;
            d.rx_st = RX_HUNT;
          end
        end
      endcase
    end

    // Transmit sequencing on the microsecond tick
    // Mismatch is judged over a window, which hides synchroniser lag
    if (q.tick) begin
      if (tx_on && q.tx_lvl != line) d.mis = q.mis + 10'h001;
      else d.mis = 10'h000;
      if (line == q.tx_lvl) d.seen = 1'b1;
      case (q.tx_st)
        TX_WAIT: begin
          // Shorted-high bus never idles, so start is held off
          if (dec_idle) begin
            d.tx_st = TX_SOF;
            d.tx_lvl = 1'b1;
            d.tx_tmr = `VPH_T_SOF;
            d.crc_sent = 1'b0;
            d.more = 1'b0;
            d.app = 2'h0;
            d.tx_bits = 3'h0;
            d.mis = 10'h000;
            d.seen = 1'b0;
            load = 1'b1;
          end
        end
        TX_SOF, TX_BITS, TX_EOD: begin
          if (q.mis == `VPH_LOOP_US) begin
            if (q.tx_lvl) begin
              d.f_sym = 1'b1;
              tx_kill = 1'b1;
            end else if (q.tx_st == TX_EOD) begin
              d.f_sym = 1'b1;
              tx_kill = 1'b1;
            end else if (q.app != 2'h0) begin
              tx_kill = 1'b1;
            end else if (!q.seen && q.tx_bits == 3'h0 && q.more) begin
              d.f_loa = 1'b1;
              d.app = `VPH_APP_N;
              d.tx_tmr = `VPH_T_LONG;
              d.mis = 10'h000;
            end else begin
              d.f_loa = 1'b1;
              tx_kill = 1'b1;
            end
          end else if (q.tx_tmr != 10'h001) begin
            d.tx_tmr = q.tx_tmr - 10'h001;
          end else begin
            d.seen = 1'b0;
            d.mis = 10'h000;
            case (q.tx_st)
              TX_SOF: begin
                d.tx_st = TX_BITS;
                d.tx_lvl = 1'b0;
                d.tx_tmr = tlen(1'b0, q.tx_sh[7]);
              end
              TX_BITS: begin
                d.tx_lvl = nlvl;
                if (q.app != 2'h0) begin
                  d.app = q.app - 2'h1;
                  d.tx_tmr = tlen(nlvl, 1'b1);
                  if (q.app == 2'h1) tx_kill = 1'b1;
                end else begin
                  d.tx_sh = {q.tx_sh[6:0], 1'b0};
                  d.tx_bits = q.tx_bits + 3'h1;
                  if (q.tx_bits == `VPH_BIT_LAST) begin
                    d.more = 1'b1;
                    if (q.tx_full) begin
                      load = 1'b1;
                      nbit = q.tx_buf[7];
                    end else if (!q.crc_sent) begin
                      d.tx_sh = ~q.tx_crc;
                      d.crc_sent = 1'b1;
                      nbit = ~q.tx_crc[7];
                    end else begin
                      d.tx_st = TX_EOD;
                    end
                  end
                  if (d.tx_st == TX_EOD) d.tx_tmr = `VPH_T_EOD;
                  else d.tx_tmr = tlen(nlvl, nbit);
                end
              end
              default: begin
                d.tx_st = TX_IDLE;
                d.tx_lvl = 1'b0;
              end
            endcase
          end
        end
        default: d.mis = 10'h000;
      endcase
    end

    // Shadow to shift register; check byte runs over sent data
    if (load) begin
      d.tx_sh = q.tx_buf;
      d.tx_full = 1'b0;
      d.f_tx_data_empty_flag = 1'b1;
      if (q.tx_st == TX_WAIT) begin
        d.tx_crc = crc_byte(`VPH_CRC_INIT, q.tx_buf);
      end else begin
        d.tx_crc = crc_byte(q.tx_crc, q.tx_buf);
      end
    end
    // Abort drops the line and the pending byte; no automatic retry
    if (tx_kill) begin
      d.tx_st = TX_IDLE;
      d.tx_lvl = 1'b0;
      d.tx_full = 1'b0;
      d.app = 2'h0;
      d.mis = 10'h000;
    end
    // A data write refills the shadow, so it outranks the empty flag
    if (reg_wr_in && reg_addr_in == `VPH_A_DATA) begin
      d.tx_buf = reg_wdata_in;
      d.tx_full = 1'b1;
      d.f_tx_data_empty_flag = 1'b0;
      if (d.tx_st == TX_IDLE) d.tx_st = TX_WAIT;
    end

    // Clearing the enable drops the request; flags stay for polling
    d.irq = q.ie & (q.f_eof | q.f_ifr | q.f_rx_data_full_flag | q.f_tx_data_empty_flag |
                    q.f_loa | q.f_crc | q.f_sym);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign reg_rdata_out = q.rdata;
  assign tx_output_pin_out = q.tx_lvl;
  assign irq_out = q.irq;
endmodule

// ===== logic/vph_pkg.sv
// Types for the VPW link protocol handler
// Assumes vph_defs.svh is on the include path
package vph_pkg;
  `include "vph_defs.svh"
  typedef enum logic [2:0] {
    SYM_B0 = 3'b000, SYM_B1 = 3'b001, SYM_SOF = 3'b010,
    SYM_EOD = 3'b011, SYM_EOF = 3'b100, SYM_BRK = 3'b101,
    SYM_BAD = 3'b110
  } vph_sym_t;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00, RX_DATA = 2'b01, RX_RESP = 2'b10
  } vph_rx_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_WAIT = 3'b001, TX_SOF = 3'b010,
    TX_BITS = 3'b011, TX_EOD = 3'b100
  } vph_tx_t;
  typedef struct packed {
    logic [9:0] cnt;
    logic lvl, fast, ign, idle, eofd, brkd, sv;
    vph_sym_t sym;
  } vph_dec_t;
  typedef struct packed {
    logic s1, s2, s3, rxl;
    logic [4:0] div;
    logic tick, ie, loop, fast_en, irq;
    logic [7:0] rdata;
    logic f_eof, f_ifr, f_rx_data_full_flag, f_tx_data_empty_flag, f_loa, f_crc, f_sym;
    vph_rx_t rx_st;
    logic [7:0] rx_sh, rx_buf, rx_crc;
    logic [2:0] rx_bits;
    vph_tx_t tx_st;
    logic [7:0] tx_buf, tx_sh, tx_crc;
    logic [2:0] tx_bits;
    logic tx_full, crc_sent, tx_lvl, seen, more;
    logic [9:0] tx_tmr, mis;
    logic [1:0] app;
  } vph_top_t;
endpackage

// ===== logic/vph_sym_dec.sv
// Pulse width symbol decoder for the VPW link
// Assumes a clean same-clock line level and a 1 us tick
`timescale 1ns/1ps
`include "vph_defs.svh"
module vph_sym_dec
  import vph_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Time base and line
  input wire logic us_tick_in,
  input wire logic line_in,
  input wire logic fast_en_in,
  // Decoded symbols
  output logic sym_valid_out,
  output vph_sym_t sym_out,
  output logic idle_out
);
  vph_dec_t q, d;
  logic start;
  logic fast4;
  logic [9:0] w;

  function automatic vph_sym_t classify(input logic act,
                                        input logic [9:0] t);
    vph_sym_t s;
    s = SYM_BAD;
    if (t < `VPH_W_MIN) s = SYM_BAD;
    else if (act) begin
      if (t < `VPH_W_SL) s = SYM_B1;
      else if (t < `VPH_W_LS) s = SYM_B0;
      else s = SYM_SOF;
    end else begin
      if (t < `VPH_W_SL) s = SYM_B0;
      else if (t < `VPH_W_LS) s = SYM_B1;
      else if (t < `VPH_W_EOF) s = SYM_EOD;
      else s = SYM_EOF;
    end
    return s;
  endfunction

  always_comb begin
    d = q;
    d.sv = 1'b0;
    start = q.eofd;
    // First pulse of a frame tells its speed
    fast4 = start && q.cnt >= `VPH_W4_LO && q.cnt <= `VPH_W4_HI;
    w = ((q.fast && !start) || fast4) ? {q.cnt[7:0], 2'b00} : q.cnt;
    if (line_in != q.lvl) begin
      d.lvl = line_in;
      d.cnt = '0;
      if (q.lvl) begin
        if (start) begin
          d.fast = fast4 & fast_en_in;
          d.ign = fast4 & ~fast_en_in;
        end
        if (!q.brkd && !d.ign) begin
          d.sv = 1'b1;
          d.sym = classify(1'b1, w);
        end
        d.eofd = 1'b0;
        d.brkd = 1'b0;
      end else begin
        d.idle = 1'b0;
        if (!q.eofd && !q.ign) begin
          d.sv = 1'b1;
          d.sym = classify(1'b0, w);
        end
      end
    end else if (us_tick_in) begin
      if (q.cnt != `VPH_CNT_MAX) d.cnt = q.cnt + 10'h001;
      // Break is flagged while still active, not at its end
      if (q.lvl && w >= `VPH_W_BRK && !q.brkd) begin
        d.brkd = 1'b1;
        d.sv = ~q.ign;
        d.sym = SYM_BRK;
      end
      if (!q.lvl && w >= `VPH_W_EOF && !q.eofd) begin
        d.eofd = 1'b1;
        d.sv = ~q.ign;
        d.sym = SYM_EOF;
      end
      if (!q.lvl && w >= `VPH_W_IDLE) begin
        d.idle = 1'b1;
        d.ign = 1'b0;
        d.fast = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign sym_valid_out = q.sv;
  assign sym_out = q.sym;
  assign idle_out = q.idle;
endmodule
